// ==== rtl/dsw_regs.vh ====
/*
 * constants for the dll off-to-on switch sequencer: register map of the
 * controller's own command port, memory command encodings, mode register
 * bit positions and interval counts.
 * assumes a 250 mhz sys_clk; the memory clock counts are given in sys_clk
 * cycles, one command slot per sys_clk edge.
 */
`ifndef DSW_REGS_VH
`define DSW_REGS_VH

// ------------------------------------------------------------
// software port map
// ------------------------------------------------------------
`define DSW_ADDR_CTRL      4'h0
`define DSW_ADDR_STATUS    4'h1
`define DSW_ADDR_MR0       4'h2
`define DSW_ADDR_MR1       4'h3
`define DSW_ADDR_MR2       4'h4
`define DSW_ADDR_MR3       4'h5
`define DSW_CTRL_START     0
`define DSW_CTRL_ZQ        1
`define DSW_CTRL_ODT_EN    2
`define DSW_CTRL_CLK_OK    3

// ------------------------------------------------------------
// command encodings {cs_b, ras_b, cas_b, we_b}
// ------------------------------------------------------------
`define DSW_CMD_NOP        4'h7
`define DSW_CMD_MRS        4'h0
`define DSW_CMD_SRE        4'h1
`define DSW_CMD_LONG_CALIBRATION_COMMAND       4'h6
`define DSW_CMD_PREA       4'h2

`define DSW_MR1_DLL_OFF    0
`define DSW_MR0_DLL_RESET  8

// ------------------------------------------------------------
// interval counts in clock_cycle_unit
// ------------------------------------------------------------
`define DSW_PERIOD_PS      4000
`define DSW_CKSRE_NS       10
`define DSW_CKSRX_NS       10
`define DSW_XS_NS          170
`define DSW_CKSRE_CYC      ((`DSW_CKSRE_NS * 1000 + `DSW_PERIOD_PS - 1) / `DSW_PERIOD_PS)
`define DSW_CKSRX_CYC      ((`DSW_CKSRX_NS * 1000 + `DSW_PERIOD_PS - 1) / `DSW_PERIOD_PS)
`define DSW_XS_CYC         ((`DSW_XS_NS * 1000 + `DSW_PERIOD_PS - 1) / `DSW_PERIOD_PS)
`define DSW_MRD_CYC        4
`define DSW_MOD_CYC        12
`define DSW_DLLK_CYC       512
`define DSW_ZQOPER_CYC     512
`define DSW_RP_CYC         4

`endif

// ==== rtl/dsw_counter.v ====
/*
 * one interval down-counter; load with a count, done when it reaches zero.
 * assumes the loader holds off reload until it wants a fresh interval.
 */
`timescale 1ns/1ps
module dsw_counter (
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire        load,
	input  wire [11:0] count,
	output wire        done
);
	reg [11:0] cnt_reg;

	// ------------------------------------------------------------
	// counting
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			cnt_reg <= 12'h000;
		else if (load)
			cnt_reg <= count;
		else if (cnt_reg != 12'h000)
			cnt_reg <= cnt_reg - 12'h001; // one per real edge
	end

	assign done = (cnt_reg == 12'h000);
endmodule

// ==== rtl/dsw_mreg.v ====
/*
 * four mode register words written by software, read back registered.
 * assumes one write or one read per cycle.
 */
`timescale 1ns/1ps
module dsw_mreg (
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire        wr,
	input  wire [1:0]  wr_idx,
	input  wire [15:0] wr_data,
	input  wire [1:0]  rd_idx,
	output reg  [15:0] rd_data
);
	reg [15:0] mem_reg [0:3];
	genvar i;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_word
			always @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b)
					mem_reg[i] <= 16'h0000;
				else if (wr && wr_idx == i)
					mem_reg[i] <= wr_data;
			end
		end
	endgenerate

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			rd_data <= 16'h0000;
		else
			rd_data <= mem_reg[rd_idx];
	end
endmodule

// ==== rtl/dsw_top.v ====
/*
 * controller that moves a ddr3 memory from dll-off to dll-on operation with
 * a clock change in self refresh. drives cke, termination_control and the
 * command/address pins; software sets mode values and starts it.
 * assumes the external clock generator changes frequency when told and
 * reports a stable clock on clk_stable.
 */
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "dsw_regs.vh"
module dsw_top (
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire [3:0]  sw_addr,
	input  wire [15:0] sw_wdata,
	input  wire        sw_wr,
	input  wire        sw_rd,
	output reg  [15:0] sw_rdata,
	input  wire        clk_stable,
	output reg         freq_change_req,
	output reg         cke,
	output reg         termination_control,
	output reg  [3:0]  cmd,
	output reg  [2:0]  bank,
	output reg  [15:0] addr,
	output reg         busy,
	output reg         dll_ready
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam S_IDLE    = 4'h0;
	localparam S_PREA    = 4'h1;
	localparam S_SRE     = 4'h2;
	localparam S_HOLD    = 4'h3;
	localparam S_FREQ    = 4'h4;
	localparam S_STABLE  = 4'h5;
	localparam S_XS      = 4'h6;
	localparam S_MR1ON   = 4'h7;
	localparam S_MR0RST  = 4'h8;
	localparam S_MRPROG  = 4'h9;
	localparam S_MODWAIT = 4'ha;
	localparam S_ZQ      = 4'hb;
	localparam S_FINAL   = 4'hc;

	// nanosecond intervals rounded up to whole cycles
	localparam [11:0] CKSRE_CNT = `DSW_CKSRE_CYC;
	localparam [11:0] CKSRX_CNT = `DSW_CKSRX_CYC;
	localparam [11:0] XS_CNT    = `DSW_XS_CYC;

	reg  [3:0]  state_reg;
	reg  [3:0]  state_next;
	reg  [1:0]  mr_idx_reg;
	reg         zq_req_reg;
	reg         odt_en_reg;
	reg         zq_done_reg;
	reg         start_pend_reg;
	reg         clk_stable_reg;
	reg         rd_mode_reg;

	wire        ctrl_wr = sw_wr && (sw_addr == `DSW_ADDR_CTRL);
	wire        mr_wr   = sw_wr && (sw_addr >= `DSW_ADDR_MR0) && (sw_addr <= `DSW_ADDR_MR3);
	wire [1:0]  mr_wr_idx = sw_addr[1:0] - 2'h2;
	wire [15:0] mr_word;
	wire [1:0]  mr_rd_idx;

	// ------------------------------------------------------------
	// interval counters: one shared step counter, one lock, one calibration
	// ------------------------------------------------------------
	reg         ld_gen;
	reg  [11:0] ld_gen_val;
	reg         ld_dllk;
	reg         ld_zq;
	wire        gen_done;
	wire        dllk_done;
	wire        zq_done;

	// general step wait, reused serially for one interval at a time
	dsw_counter u_gen (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.load    (ld_gen),
		.count   (ld_gen_val),
		.done    (gen_done)
	);
	// lock wait runs from dll reset independently
	dsw_counter u_dllk (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.load    (ld_dllk),
		.count   (12'd`DSW_DLLK_CYC),
		.done    (dllk_done)
	);
	dsw_counter u_zq (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.load    (ld_zq),
		.count   (12'd`DSW_ZQOPER_CYC),
		.done    (zq_done)
	);

	// mode values; during programming the sequencer reads, otherwise sw_addr sets the index, though sw_rdata never returns the word
	// exit wait prefetches the mode one word for the dll enable write
	assign mr_rd_idx = rd_mode_reg ? sw_addr[1:0] - 2'h2 :
	                   (state_reg == S_XS) ? 2'h1 : mr_idx_reg;
	dsw_mreg u_mreg (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.wr      (mr_wr && !busy),
		.wr_idx  (mr_wr_idx),
		.wr_data (sw_wdata),
		.rd_idx  (mr_rd_idx),
		.rd_data (mr_word)
	);

	// ------------------------------------------------------------
	// control register and sampled clock status
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			zq_req_reg     <= 1'b0;
			odt_en_reg     <= 1'b0;
			start_pend_reg <= 1'b0;
			clk_stable_reg <= 1'b0;
		end else begin
			clk_stable_reg <= clk_stable;
			if (ctrl_wr && !busy) begin
				zq_req_reg <= sw_wdata[`DSW_CTRL_ZQ];
				odt_en_reg <= sw_wdata[`DSW_CTRL_ODT_EN];
			end
			// set wins over the consume in the same cycle
			if (ctrl_wr && sw_wdata[`DSW_CTRL_START] && !busy)
				start_pend_reg <= 1'b1;
			else if (state_reg == S_IDLE)
				start_pend_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		ld_gen     = 1'b0;
		ld_gen_val = 12'h000;
		ld_dllk    = 1'b0;
		ld_zq      = 1'b0;
		case (state_reg)
			S_IDLE: begin
				if (start_pend_reg) begin
					state_next = S_PREA;
					ld_gen     = 1'b1;
					ld_gen_val = 12'd`DSW_RP_CYC;
				end
			end
			S_PREA: begin
				if (gen_done)
					state_next = S_SRE; // all banks idle before entry
			end
			S_SRE: begin
				state_next = S_HOLD;
				ld_gen     = 1'b1;
				ld_gen_val = CKSRE_CNT;
			end
			S_HOLD: begin
				if (gen_done)
					state_next = S_FREQ; // clock held after entry
			end
			S_FREQ: begin
				if (clk_stable_reg) begin
					state_next = S_STABLE;
					ld_gen     = 1'b1;
					ld_gen_val = CKSRX_CNT;
				end
			end
			S_STABLE: begin
				if (!clk_stable_reg)
					state_next = S_FREQ;
				else if (gen_done) begin
					state_next = S_XS; // exit only after stable interval
					ld_gen     = 1'b1;
					ld_gen_val = XS_CNT;
				end
			end
			S_XS: begin
				if (gen_done)
					state_next = S_MR1ON;
			end
			S_MR1ON: begin
				state_next = S_MR0RST;
				ld_gen     = 1'b1;
				// this state uses one slot, so the reset write lands mrd after
				ld_gen_val = 12'd`DSW_MRD_CYC - 12'd2;
			end
			S_MR0RST: begin
				if (gen_done) begin
					state_next = S_MRPROG;
					ld_dllk    = 1'b1;
					ld_gen     = 1'b1;
					ld_gen_val = 12'd`DSW_MRD_CYC - 12'd1;
				end
			end
			S_MRPROG: begin
				// issues each stored word, mrd apart
				if (gen_done) begin
					ld_gen     = 1'b1;
					ld_gen_val = (mr_idx_reg == 2'h3) ? 12'd`DSW_MOD_CYC - 12'd1
					                                : 12'd`DSW_MRD_CYC - 12'd1;
					if (mr_idx_reg == 2'h3)
						state_next = S_MODWAIT;
				end
			end
			S_MODWAIT: begin
				if (gen_done) begin
					if (zq_req_reg) begin
						state_next = S_ZQ; // after mod from all writes
						ld_zq      = 1'b1;
					end else
						state_next = S_FINAL;
				end
			end
			S_ZQ: begin
				if (zq_done)
					state_next = S_FINAL;
			end
			S_FINAL: begin
				if (dllk_done)
					state_next = S_IDLE; // lock done before any locked command
			end
			default: state_next = S_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// pins and state
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg           <= S_IDLE;
			mr_idx_reg          <= 2'h0;
			cke                 <= 1'b1;
			termination_control <= 1'b0;
			cmd                 <= `DSW_CMD_NOP;
			bank                <= 3'h0;
			addr                <= 16'h0000;
			busy                <= 1'b0;
			dll_ready           <= 1'b0;
			freq_change_req     <= 1'b0;
			zq_done_reg         <= 1'b0;
		end else begin
			state_reg           <= state_next;
			cmd                 <= `DSW_CMD_NOP; // nop in every wait
			bank                <= 3'h0;
			addr                <= 16'h0000;
			termination_control <= 1'b0; // low throughout, odt held off even with odt_en_reg set
			busy                <= (state_next != S_IDLE);
			freq_change_req     <= (state_next == S_FREQ);
			case (state_reg)
				S_IDLE: begin
					if (start_pend_reg) begin
						dll_ready <= 1'b0;
						zq_done_reg <= 1'b0;
						cmd  <= `DSW_CMD_PREA;
						addr <= 16'h0400;
					end
				end
				S_PREA: begin
					if (gen_done) begin
						cmd <= `DSW_CMD_SRE;
						cke <= 1'b0;
					end
				end
				S_STABLE: begin
					if (clk_stable_reg && gen_done)
						cke <= 1'b1; // exit, high until lock
				end
				S_XS: begin
					if (gen_done) begin
						cmd  <= `DSW_CMD_MRS;
						bank <= 3'h1;
						addr <= mr_word & ~(16'h0001 << `DSW_MR1_DLL_OFF);
					end
				end
				S_MR0RST: begin
					if (gen_done) begin
						cmd  <= `DSW_CMD_MRS;
						bank <= 3'h0;
						addr <= mr_word | (16'h0001 << `DSW_MR0_DLL_RESET);
					end
				end
				S_MRPROG: begin
					if (gen_done) begin
						cmd        <= `DSW_CMD_MRS;
						bank       <= {1'b0, mr_idx_reg};
						addr       <= (mr_idx_reg == 2'h1)
						              ? (mr_word & ~(16'h0001 << `DSW_MR1_DLL_OFF)) : mr_word;
						mr_idx_reg <= mr_idx_reg + 2'h1;
					end
				end
				S_MODWAIT: begin
					if (gen_done && zq_req_reg) begin
						cmd  <= `DSW_CMD_LONG_CALIBRATION_COMMAND;
						addr <= 16'h0400;
					end
				end
				S_ZQ: begin
					if (zq_done)
						zq_done_reg <= 1'b1;
				end
				S_FINAL: begin
					if (dllk_done)
						dll_ready <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// mode word fetch index; sequencer steps mr_idx so next word is ready
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_mode_reg <= 1'b1;
		end else begin
			rd_mode_reg <= !(state_next == S_XS || state_next == S_MR1ON
			              || state_next == S_MR0RST || state_next == S_MRPROG);
		end
	end

	// ------------------------------------------------------------
	// software read port, data one cycle after strobe
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_rdata <= 16'h0000;
		end else begin
			case (sw_addr)
				`DSW_ADDR_CTRL:   sw_rdata <= {12'h000, 1'b0, odt_en_reg, zq_req_reg, 1'b0};
				`DSW_ADDR_STATUS: sw_rdata <= {8'h00, state_reg, 1'b0, zq_done_reg,
				                               dll_ready, busy};
				default:          sw_rdata <= 16'h0000;
			endcase
		end
	end
endmodule

// ==== tb/dsw_mem_model.sv ====
/*
 * memory device model for the dll switch bench: keeps mode register one,
 * reports dll state and counts command spacing faults.
 * assumes command pins are registered on sys_clk, one slot per edge.
 */
`timescale 1ns/1ps
`include "dsw_regs.vh"
module dsw_mem_model (
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire [3:0]  cmd,
	input  wire [2:0]  bank,
	input  wire [15:0] addr,
	output logic       dll_on,
	output logic [7:0] err
);
	// ------------------------------
	// mode state and spacing watch
	// ------------------------------
	logic [15:0] mr1_reg;
	logic        last_mrs;
	int          gap;

	assign dll_on = !mr1_reg[`DSW_MR1_DLL_OFF];

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mr1_reg <= 16'h0001;
			last_mrs <= 1'b0;
			gap <= 999;
			err <= 8'h00;
		end else if (cmd != `DSW_CMD_NOP) begin
			// spacing in real edges, jitter ignored
			if (last_mrs && cmd == `DSW_CMD_MRS && gap < `DSW_MRD_CYC)
				err <= err + 8'h01;
			// other commands only once modereg_to_command_delay ran out
			if (last_mrs && cmd != `DSW_CMD_MRS && gap < `DSW_MOD_CYC)
				err <= err + 8'h01;
			if (cmd == `DSW_CMD_MRS && bank == 3'h1)
				mr1_reg <= addr;
			last_mrs <= (cmd == `DSW_CMD_MRS);
			gap <= 1;
		end else if (gap < 999) begin
			gap <= gap + 1;
		end
	end
endmodule

// ==== tb/dsw_top_sva.sv ====
/*
 * checker for the dll off-to-on sequencer, bound to dsw_top.
 * assumes only the top ports are visible; counters saturate.
 */
`timescale 1ns/1ps
`include "dsw_regs.vh"
module dsw_top_sva (
	input wire        sys_clk,
	input wire        rst_b,
	input wire        clk_stable,
	input wire        freq_change_req,
	input wire        cke,
	input wire        termination_control,
	input wire [3:0]  cmd,
	input wire [2:0]  bank,
	input wire [15:0] addr,
	input wire        busy,
	input wire        dll_ready
);
	// ------------------------------
	// interval counters
	// ------------------------------
	logic [10:0] gap, xs, lk, zq;
	logic        cke_d;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			gap <= 11'h7ff;
			xs <= 11'h7ff;
			lk <= 11'h000;
			zq <= 11'h7ff;
			cke_d <= 1'b1;
		end else begin
			cke_d <= cke;
			gap <= (cmd != `DSW_CMD_NOP) ? 11'h1 : gap + {10'h0, gap != 11'h7ff};
			xs <= (cke && !cke_d) ? 11'h1 : xs + {10'h0, xs != 11'h7ff};
			lk <= (cmd == `DSW_CMD_MRS && bank == 3'h0 && addr[8]) ? 11'h1 :
				lk + {10'h0, lk != 11'h7ff};
			zq <= (cmd == `DSW_CMD_LONG_CALIBRATION_COMMAND) ? 11'h1 : zq + {10'h0, zq != 11'h7ff};
		end
	end

	// ------------------------------
	// properties
	// ------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence exit_s;
		!cke ##1 cke;
	endsequence
	sequence dllrst_s;
		cmd == `DSW_CMD_MRS && bank == 3'h0 && addr[8];
	endsequence

	sre_cke_a: assert property ($fell(cke) |-> cmd == `DSW_CMD_SRE)
		else $error("cke fell without self refresh entry");
	freq_hold_a: assert property ($rose(freq_change_req) |-> !cke && !$past(cke, 3))
		else $error("clock change asked too soon");
	stable_exit_a: assert property (exit_s |->
		$past(clk_stable) && $past(clk_stable, 2) && $past(clk_stable, 3))
		else $error("exit without stable clock");
	cke_hold_a: assert property (dllrst_s |-> cke ##1 cke [*8])
		else $error("cke dropped during lock");
	mrs_cke_a: assert property (cmd == `DSW_CMD_MRS |-> cke)
		else $error("mode write with cke low");
	term_low_a: assert property (busy |-> !termination_control)
		else $error("termination high in sequence");
	xs_wait_a: assert property (cmd == `DSW_CMD_MRS |-> xs >= `DSW_XS_CYC)
		else $error("mode write before exit delay");
	dll_on_a: assert property (cmd == `DSW_CMD_MRS && bank == 3'h1 |-> !addr[0])
		else $error("dll left off");
	reset_order_a: assert property (dllrst_s |->
		$past(cmd == `DSW_CMD_MRS && bank == 3'h1, 4))
		else $error("dll reset not four after mode one");
	mrd_gap_a: assert property (cmd == `DSW_CMD_MRS |-> gap >= `DSW_MRD_CYC)
		else $error("mode writes too close");
	zq_mod_a: assert property (cmd == `DSW_CMD_LONG_CALIBRATION_COMMAND |-> gap >= `DSW_MOD_CYC)
		else $error("calibration before modereg_to_command_delay");
	lock_wait_a: assert property ($rose(dll_ready) |->
		lk >= `DSW_DLLK_CYC && zq >= `DSW_ZQOPER_CYC)
		else $error("ready before lock or calibration");
endmodule

bind dsw_top dsw_top_sva dsw_top_sva_inst (.sys_clk, .rst_b, .clk_stable,
	.freq_change_req, .cke, .termination_control, .cmd, .bank, .addr, .busy, .dll_ready);

// ==== tb/testbench.sv ====
/*
 * self-checking bench for dsw_top: runs the switch with and without long
 * calibration, random mode words, a clock-stable glitch, refused writes.
 * assumes the memory model sits on the command pins.
 */
`timescale 1ns/1ps
`include "dsw_regs.vh"
module testbench;
	logic        sys_clk, rst_b, sw_wr, sw_rd, clk_stable;
	logic        freq_change_req, cke, termination_control, busy, dll_ready, dll_on;
	logic [3:0]  sw_addr, cmd;
	logic [2:0]  bank;
	logic [15:0] sw_wdata, sw_rdata, addr, d;
	logic [15:0] mw [4];
	logic [7:0]  mem_err;
	logic [22:0] ev [$], gq [$];
	int          fails, num_checks, seed;

	dsw_top dsw_top_inst (.sys_clk, .rst_b, .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
		.sw_rdata, .clk_stable, .freq_change_req, .cke, .termination_control,
		.cmd, .bank, .addr, .busy, .dll_ready);
	dsw_mem_model dsw_mem_model_inst (.sys_clk, .rst_b, .cmd, .bank, .addr,
		.dll_on, .err(mem_err));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// nop cycles are not recorded, only real commands
	always @(posedge sys_clk) begin
		if (rst_b && cmd !== `DSW_CMD_NOP) gq.push_back({cmd, bank, addr});
	end

	task automatic check(input logic [22:0] seen, input logic [22:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= v;
		@(posedge sys_clk);
		sw_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		sw_rd <= 1'b1;
		sw_addr <= a;
		@(posedge sys_clk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask

	// bounded wait on freq_change_req (0) or dll_ready (1)
	task automatic wait_on(input int which, input int n);
		int k = 0;
		while ((which ? dll_ready : freq_change_req) !== 1'b1 && k < n) begin
			@(posedge sys_clk);
			k++;
		end
		if ((which ? dll_ready : freq_change_req) !== 1'b1) begin
			fails++;
			print_verdict();
		end
	endtask

	// bank of non-mode commands is left open, and address too for self refresh entry
	function automatic logic [22:0] msk(input logic [22:0] e);
		if (e[22:19] == `DSW_CMD_SRE) return 23'h780000;
		if (e[22:19] != `DSW_CMD_MRS) return 23'h78ffff;
		return 23'h7fffff;
	endfunction

	initial begin
		seed = 32'h2d4763f6;
		{rst_b, sw_wr, sw_rd, clk_stable, sw_addr, sw_wdata} = '0;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(4'hf);
		check(d, 0);
		for (int z = 1; z >= 0; z--) begin
			for (int i = 0; i < 4; i++) mw[i] = 16'($random(seed));
			mw[0][8] = 1'b0;
			mw[1][0] = 1'b1;
			for (int i = 0; i < 4; i++) wr(4'(`DSW_ADDR_MR0 + i), mw[i]);
			ev = {};
			ev.push_back({`DSW_CMD_PREA, 3'h0, 16'h0400});
			ev.push_back({`DSW_CMD_SRE, 19'h0});
			ev.push_back({`DSW_CMD_MRS, 3'h1, mw[1] & 16'hfffe});
			ev.push_back({`DSW_CMD_MRS, 3'h0, mw[0] | 16'h0100});
			for (int i = 0; i < 4; i++)
				ev.push_back({`DSW_CMD_MRS, 3'(i), i == 1 ? mw[1] & 16'hfffe : mw[i]});
			if (z == 1) ev.push_back({`DSW_CMD_LONG_CALIBRATION_COMMAND, 3'h0, 16'h0400});
			gq = {};
			wr(`DSW_ADDR_CTRL, {14'h0, z[0], 1'b1});
			wr(`DSW_ADDR_MR3, ~mw[3]);
			rd(`DSW_ADDR_STATUS);
			check(d & 16'h3, 16'h1);
			wait_on(0, 200);
			repeat (2 + ($unsigned($random(seed)) % 8)) @(posedge sys_clk);
			clk_stable <= 1'b1;
			// short glitch must restart the stable count
			if (z == 1) begin
				@(posedge sys_clk);
				clk_stable <= 1'b0;
				@(posedge sys_clk);
				clk_stable <= 1'b1;
			end
			wait_on(1, 3000);
			check(23'(gq.size()), 23'(ev.size()));
			for (int i = 0; i < ev.size() && i < gq.size(); i++)
				check(gq[i] & msk(ev[i]), ev[i]);
			rd(`DSW_ADDR_STATUS);
			check(d & 16'h3, 16'h2);
			check({cke, termination_control}, 2'b10);
			check(dll_on, 1'b1);
			check(mem_err, 8'h00);
			@(posedge sys_clk);
			clk_stable <= 1'b0;
		end
		print_verdict();
	end
endmodule
